/* tlll_pkg.sv */
package tlll_pkg;
    // serial word and latch-select field
    localparam int WORD_W = 24;
    localparam int SEL_W = 2;
    localparam int SEL_LSB = 0;
    localparam int NUM_LATCH = 4;
    localparam logic [1:0] SEL_CONTROL = 2'h0;
    localparam logic [1:0] SEL_REF = 2'h1;
    localparam logic [1:0] SEL_FB = 2'h2;
    localparam logic [1:0] SEL_TEST = 2'h3;
    localparam logic [23:0] LATCH_RST = 24'h000000;
    // control latch fields
    localparam int PD_CORE_BIT = 20;
    localparam int PD_CP_BIT = 21;
    localparam int MON_LSB = 5;
    localparam int MON_W = 3;
    localparam logic [2:0] MON_LOCK = 3'h1;
    localparam logic [2:0] MON_RF = 3'h2;
    localparam logic [2:0] MON_REF = 3'h4;
    // synchroniser lanes
    localparam int SYNC_N = 5;
    localparam int LN_STROBE = 0;
    localparam int LN_CE = 1;
    localparam int LN_LOCK = 2;
    localparam int LN_RF = 3;
    localparam int LN_REF = 4;
endpackage

/* tlll_shift_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface tlll_shift_if #(
    parameter int W = tlll_pkg::WORD_W
);
    logic [W-1:0] word;
    modport src (output word);
    modport dst (input word);
endinterface
`default_nettype wire

/* tlll_shifter.sv */
`timescale 1ns/1ps
`default_nettype none
module tlll_shifter #(
    parameter int W = tlll_pkg::WORD_W
) (
    input wire logic serial_clock_i, // link clock, idle outside frames
    input wire logic serial_data_i,  // serial data bit
    tlll_shift_if.src shift_o        // current shift word
);
    logic [W-1:0] shift_ff;
    logic [W-1:0] nxt_shift;

    // no reset: the link clock may never tick during reset
    // RULE1: shift in on rise
    always_comb
    begin
        nxt_shift = {shift_ff[W-2:0], serial_data_i};
    end

    always_ff @(posedge serial_clock_i)
    begin
        shift_ff <= nxt_shift;
    end

    assign shift_o.word = shift_ff;
endmodule
`default_nettype wire

/* tlll_top.sv */
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// RULE1: each serial clock rise shifts the data bit into a 24-bit register.
// RULE2: host sends MSB first so the last bit lands in bit zero.
// RULE3: the two lowest word bits select the destination latch at strobe rise.
// RULE4: a load strobe rising edge copies the word into exactly one latch.
// RULE5: only the selected latch changes; the other three keep their contents.
// RULE6: chip enable low powers down and three-states the charge pump output.
// RULE7: chip enable high powers up only where power-down bits are clear.
// RULE8: monitor output shows lock detect, divided RF or divided reference.
// RULE9: select 00 control, 01 reference, 10 feedback, 11 factory test latch.
// RULE10: host never loads a word whose select field is 11.
// RULE11: host writes reference, then control, then feedback latch at power-up.
// RULE12: shifting with the strobe low never changes any latch output.
module tlll_top #(
    parameter int WORD_W = tlll_pkg::WORD_W
) (
    input wire logic clock_i,                  // system clock, 50 MHz
    input wire logic reset_i,                  // sync reset, active high
    input wire logic serial_clock_i,           // serial clock from host
    input wire logic serial_data_i,            // serial data from host
    input wire logic load_strobe_i,            // load strobe from host
    input wire logic chip_enable_i,            // chip enable pin
    input wire logic lock_detect_i,            // lock detect source
    input wire logic rf_div_i,                 // divided RF source
    input wire logic ref_div_i,                // divided reference source
    output logic [WORD_W-1:0] control_latch_o, // control latch
    output logic [WORD_W-1:0] ref_latch_o,     // reference divider latch
    output logic [WORD_W-1:0] fb_latch_o,      // feedback divider latch
    output logic [WORD_W-1:0] test_latch_o,    // factory test latch
    output logic core_power_o,                 // core powered up
    output logic charge_pump_output_oe_o,      // charge pump driving
    output logic monitor_output_o,             // monitor pin
    output logic band_select_start_o           // pulse on feedback load
);
    localparam int SN = tlll_pkg::SYNC_N;

    generate
        if (WORD_W <= tlll_pkg::PD_CP_BIT)
        begin : g_bad_width
            $error("word too narrow for control fields");
        end
    endgenerate

    tlll_shift_if #(.W(WORD_W)) shift_if ();

    tlll_shifter #(.W(WORD_W)) u_shifter (
        .serial_clock_i(serial_clock_i),
        .serial_data_i(serial_data_i),
        .shift_o(shift_if.src)
    );

    logic [SN-1:0] sync1_ff;
    logic [SN-1:0] sync2_ff;
    logic strobe_prev_ff;
    logic [SN-1:0] nxt_sync1;
    logic [SN-1:0] nxt_sync2;
    logic nxt_strobe_prev;

    always_comb
    begin
        nxt_sync1 = {ref_div_i, rf_div_i, lock_detect_i, chip_enable_i, load_strobe_i};
        nxt_sync2 = sync1_ff;
        nxt_strobe_prev = sync2_ff[tlll_pkg::LN_STROBE];
    end

    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            sync1_ff <= '0;
            sync2_ff <= '0;
            strobe_prev_ff <= 1'b0;
        end
        else
        begin
            sync1_ff <= nxt_sync1;
            sync2_ff <= nxt_sync2;
            strobe_prev_ff <= nxt_strobe_prev;
        end
    end

    logic load_pulse;
    logic [tlll_pkg::SEL_W-1:0] sel;
    logic ce;
    assign load_pulse = sync2_ff[tlll_pkg::LN_STROBE] & ~strobe_prev_ff;
    assign sel = shift_if.word[tlll_pkg::SEL_LSB +: tlll_pkg::SEL_W];
    assign ce = sync2_ff[tlll_pkg::LN_CE];

    // the word is read across domains without its own synchroniser: the
    // serial clock is still while the strobe is high, so it is stable here
    logic [WORD_W-1:0] latch_ff [tlll_pkg::NUM_LATCH];
    logic [WORD_W-1:0] nxt_latch [tlll_pkg::NUM_LATCH];
    logic band_ff;
    logic nxt_band;

    always_comb
    begin
        nxt_latch = latch_ff;
        nxt_band = 1'b0;
        // RULE12: change only on strobe
        if (load_pulse)
        begin
            // RULE4: copy into one latch
            // RULE5: others untouched
            // RULE3: select field decides
            // RULE9: direct index decode
            nxt_latch[sel] = shift_if.word;
            // RULE11: feedback load starts band select
            nxt_band = (sel == tlll_pkg::SEL_FB);
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            for (int i = 0; i < tlll_pkg::NUM_LATCH; i++)
            begin
                latch_ff[i] <= WORD_W'(tlll_pkg::LATCH_RST);
            end
            band_ff <= 1'b0;
        end
        else
        begin
            latch_ff <= nxt_latch;
            band_ff <= nxt_band;
        end
    end

    logic [WORD_W-1:0] ctrl;
    logic [tlll_pkg::MON_W-1:0] mon_sel;
    assign ctrl = latch_ff[tlll_pkg::SEL_CONTROL];
    assign mon_sel = ctrl[tlll_pkg::MON_LSB +: tlll_pkg::MON_W];

    logic core_ff;
    logic cp_oe_ff;
    logic mon_ff;
    logic nxt_core;
    logic nxt_cp_oe;
    logic nxt_mon;

    always_comb
    begin
        // RULE6: chip enable low forces off
        // RULE7: power-down bits gate power-up
        nxt_core = ce & ~ctrl[tlll_pkg::PD_CORE_BIT];
        nxt_cp_oe = ce & ~ctrl[tlll_pkg::PD_CORE_BIT] & ~ctrl[tlll_pkg::PD_CP_BIT];
        // RULE8: monitor source select
        case (mon_sel)
            tlll_pkg::MON_LOCK: nxt_mon = sync2_ff[tlll_pkg::LN_LOCK];
            tlll_pkg::MON_RF: nxt_mon = sync2_ff[tlll_pkg::LN_RF];
            tlll_pkg::MON_REF: nxt_mon = sync2_ff[tlll_pkg::LN_REF];
            default: nxt_mon = 1'b0;
        endcase
    end

    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            core_ff <= 1'b0;
            cp_oe_ff <= 1'b0;
            mon_ff <= 1'b0;
        end
        else
        begin
            core_ff <= nxt_core;
            cp_oe_ff <= nxt_cp_oe;
            mon_ff <= nxt_mon;
        end
    end

    assign control_latch_o = latch_ff[tlll_pkg::SEL_CONTROL];
    assign ref_latch_o = latch_ff[tlll_pkg::SEL_REF];
    assign fb_latch_o = latch_ff[tlll_pkg::SEL_FB];
    assign test_latch_o = latch_ff[tlll_pkg::SEL_TEST];
    assign core_power_o = core_ff;
    assign charge_pump_output_oe_o = cp_oe_ff;
    assign monitor_output_o = mon_ff;
    assign band_select_start_o = band_ff;

    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (reset_i);

    property p_load_copy;
        load_pulse |=> latch_ff[$past(sel)] == $past(shift_if.word);
    endproperty
    a_load_copy: assert property (p_load_copy) else $error("strobe did not load word"); // RULE4

    property p_ref_decode;
        load_pulse && sel == tlll_pkg::SEL_REF |=> ref_latch_o == $past(shift_if.word);
    endproperty
    a_ref_decode: assert property (p_ref_decode) else $error("select 01 not to ref latch"); // RULE9

    property p_others_keep;
        load_pulse && sel != tlll_pkg::SEL_CONTROL |=> $stable(control_latch_o);
    endproperty
    a_others_keep: assert property (p_others_keep) else $error("unselected latch changed"); // RULE5

    property p_no_strobe_hold;
        !load_pulse |=> $stable(control_latch_o) && $stable(ref_latch_o)
            && $stable(fb_latch_o) && $stable(test_latch_o);
    endproperty
    a_no_strobe_hold: assert property (p_no_strobe_hold) else $error("latch moved without strobe"); // RULE12

    property p_band_start;
        load_pulse && sel == tlll_pkg::SEL_FB |=> band_select_start_o ##1 !band_select_start_o;
    endproperty
    a_band_start: assert property (p_band_start) else $error("feedback load gave no pulse"); // RULE11

    property p_ce_low;
        !ce |=> !charge_pump_output_oe_o && !core_power_o;
    endproperty
    a_ce_low: assert property (p_ce_low) else $error("chip enable low but powered"); // RULE6

    property p_pd_bit;
        ce && !ctrl[tlll_pkg::PD_CORE_BIT] && !ctrl[tlll_pkg::PD_CP_BIT]
            |=> core_power_o && charge_pump_output_oe_o;
    endproperty
    a_pd_bit: assert property (p_pd_bit) else $error("clear power-down bits kept off"); // RULE7

    property p_mon_lock;
        mon_sel == tlll_pkg::MON_LOCK |=> monitor_output_o == $past(sync2_ff[tlll_pkg::LN_LOCK]);
    endproperty
    a_mon_lock: assert property (p_mon_lock) else $error("monitor not showing lock"); // RULE8

    c_load_ctrl: cover property (load_pulse && sel == tlll_pkg::SEL_CONTROL);
    c_load_fb: cover property (load_pulse && sel == tlll_pkg::SEL_FB);
    c_power_up: cover property (!core_power_o ##1 core_power_o);
endmodule
`default_nettype wire

/* tlll_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module tlll_host_model (
    output logic serial_clock_o, // link clock, still between frames
    output logic serial_data_o,  // serial data
    output logic load_strobe_o   // load strobe
);
    initial
    begin
        serial_clock_o = 1'b0;
        serial_data_o = 1'b0;
        load_strobe_o = 1'b0;
    end
    task automatic send_word(input logic [23:0] w, input int gap, input bit load);
        // phase offset keeps link and strobe edges off the system clock edges
        #7;
        for (int i = 23; i >= 0; i--)
        begin
            serial_data_o = w[i];
            #(20 + gap);
            serial_clock_o = 1'b1;
            #40;
            serial_clock_o = 1'b0;
            // hold expired, no stale level left on the line
            serial_data_o = ~w[i];
            #20;
        end
        if (load)
        begin
            #20;
            load_strobe_o = 1'b1;
            // clock stays still while the word crosses domains
            #120;
            load_strobe_o = 1'b0;
            #100;
        end
    endtask
endmodule
`default_nettype wire

/* tb_three_wire_latch_loader.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_three_wire_latch_loader;
    logic clock_i = 1'b0;
    logic reset_i = 1'b1;
    logic ce = 1'b0;
    logic lock = 1'b0;
    logic rf = 1'b0;
    logic refd = 1'b0;
    logic sclk, sdat, strobe, core, oe, mon, band;
    logic [23:0] lat [4];
    logic [23:0] exp_l [4] = '{default: tlll_pkg::LATCH_RST};
    int n_errors = 0;
    int checked = 0;
    int n_band = 0;
    tlll_host_model host (.serial_clock_o(sclk), .serial_data_o(sdat), .load_strobe_o(strobe));
    tlll_top uut (
        .clock_i(clock_i), .reset_i(reset_i), .serial_clock_i(sclk), .serial_data_i(sdat),
        .load_strobe_i(strobe), .chip_enable_i(ce), .lock_detect_i(lock), .rf_div_i(rf),
        .ref_div_i(refd), .control_latch_o(lat[0]), .ref_latch_o(lat[1]),
        .fb_latch_o(lat[2]), .test_latch_o(lat[3]), .core_power_o(core),
        .charge_pump_output_oe_o(oe), .monitor_output_o(mon), .band_select_start_o(band)
    );
    initial forever #10 clock_i = ~clock_i;
    always @(posedge clock_i)
        if (band === 1'b1)
            n_band <= n_band + 1;
    task automatic print_verdict;
        if (n_errors == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clock_i);
    endtask
    task automatic chk_lat;
        for (int k = 0; k < 4; k++)
            chk(lat[k], exp_l[k]);
    endtask
    task automatic load(input logic [23:0] w, input int gap);
        int b;
        b = n_band;
        host.send_word(w, gap, 1'b1);
        exp_l[w[1:0]] = w;
        cyc(2);
        chk_lat();
        chk(24'(n_band - b), 24'(w[1:0] == tlll_pkg::SEL_FB));
    endtask
    task automatic t_noload;
        int b;
        b = n_band;
        host.send_word(24'h5a5a5a, 0, 1'b0);
        cyc(4);
        chk_lat();
        chk(24'(n_band - b), 24'h0);
    endtask
    task automatic t_power;
        logic [23:0] w;
        for (int c = 0; c < 8; c++)
        begin
            w = 24'h0;
            w[tlll_pkg::PD_CP_BIT] = c[1];
            w[tlll_pkg::PD_CORE_BIT] = c[0];
            load(w, 0);
            ce <= c[2];
            cyc(5);
            chk(core, c[2] & ~c[0]);
            chk(oe, c[2] & ~c[0] & ~c[1]);
        end
    endtask
    task automatic t_monitor;
        logic [2:0] code [4] = '{tlll_pkg::MON_LOCK, tlll_pkg::MON_RF, tlll_pkg::MON_REF, 3'h0};
        for (int k = 0; k < 4; k++)
        begin
            load({16'h0, code[k], 5'h0}, 0);
            for (int p = 0; p < 8; p++)
            begin
                {refd, rf, lock} <= p[2:0];
                cyc(5);
                chk(mon, |(code[k] & p[2:0]));
            end
        end
    endtask
    initial
    begin
        repeat (12) @(posedge clock_i);
        reset_i <= 1'b0;
        cyc(2);
        chk_lat();
        load(24'h3c5a01, 0);
        load(24'h000020, 100);
        load(24'hc3a5fe, 0);
        load(24'h81ff3d, 0);
        t_noload();
        t_power();
        t_monitor();
        print_verdict();
    end
    initial
    begin
        #300000;
        n_errors++;
        print_verdict();
    end
endmodule
`default_nettype wire
